// File: sim/haptic_waveform_sequencer_tb.sv
// Self-checking bench for the sequencer top with a player model behind it.
// Assumes a short wait unit of 8 cycles; expected requests go through a queue.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module haptic_waveform_sequencer_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic go_set = 1'b0;
    logic go_clr = 1'b0;
    logic [9:0] exp_v;
    logic [7:0] dly = 8'h02;
    logic ws, wa, cs, cd, ds, dd, wd, rtp_en, busy;
    logic [7:0] rdata;
    logic [7:0] rtp;
    logic [7:0] v;
    logic [2:0] wlib;
    logic [2:0] lib;
    logic [6:0] wid;
    logic [6:0] ids[8];
    logic [9:0] exp_q[$];
    int fail_count = 0;
    int n_compared = 0;
    int ab_n = 0;
    int cal_n = 0;
    int diag_n = 0;
    int cyc = 0;
    int c;
    time t_ws;
    time t0;

    always #2.5 clk = ~clk;

    hws_top #(.WAIT_UNIT_CYC(8)) dut_u (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .EXT_GO_SET(go_set), .EXT_GO_CLR(go_clr), .WAVE_START(ws),
        .WAVE_ABORT(wa), .WAVE_LIB(wlib), .WAVE_ID(wid), .WAVE_DONE(wd), .CAL_START(cs), .CAL_DONE(cd),
        .DIAG_START(ds), .DIAG_DONE(dd), .RTP_EN(rtp_en), .RTP_BYTE(rtp), .BUSY(busy));
    hws_player_model pm_u (.clk(clk), .rst_n(rst_n), .wave_start(ws), .wave_abort(wa), .cal_start(cs),
        .diag_start(ds), .dly(dly), .wave_done(wd), .cal_done(cd), .diag_done(dd));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watcher: oldest note is taken whenever a request appears
    always @(posedge clk) begin
        cyc++;
        ab_n += int'(wa === 1'b1);
        cal_n += int'(cs === 1'b1);
        diag_n += int'(ds === 1'b1);
        if (ws === 1'b1) begin
            t_ws = $time;
            if (exp_q.size() == 0) `CHK(ws, 1'b0)
            else begin
                exp_v = exp_q.pop_front();
                `CHK({wlib, wid}, exp_v)
            end
        end
        if (cyc > 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data is registered, so allow two edges after the address
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 `CHK(rdata, e)
    endtask

    task automatic idle();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask

    initial begin
        void'($urandom(32'he652));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then an unmapped place
        for (int i = 1; i < 13; i++) rc(i[7:0], (i == 3) ? 8'h01 : 8'h00);
        rc(8'h20, 8'h00);
        // Eight random waveforms with a slow player
        lib = 3'($urandom_range(1, 7));
        wr8(8'h03, {5'h00, lib});
        dly <= 8'h1E;
        for (int i = 0; i < 8; i++) begin
            ids[i] = 7'($urandom_range(1, 127));
            wr8(8'h04 + i[7:0], {1'b0, ids[i]});
            exp_q.push_back({lib, ids[i]});
        end
        wr8(8'h0C, 8'hFF);
        rc(8'h0C, 8'h01);
        idle();
        `CHK(exp_q.size(), 0)
        rc(8'h0C, 8'h00);
        // Zero wait passes through, zero slot ends the run
        dly <= 8'h01;
        wr8(8'h05, 8'h80);
        wr8(8'h07, 8'h00);
        exp_q.push_back({lib, ids[0]});
        exp_q.push_back({lib, ids[2]});
        wr8(8'h0C, 8'h01);
        idle();
        `CHK(exp_q.size(), 0)
        // Wait of two units ahead of a waveform
        wr8(8'h04, 8'h82);
        wr8(8'h05, {1'b0, ids[1]});
        wr8(8'h06, 8'h00);
        exp_q.push_back({lib, ids[1]});
        wr8(8'h0C, 8'h01);
        t0 = $time;
        idle();
        c = int'((t_ws - t0) / 5);
        `CHK(c >= 17 && c <= 24, 1'b1)
        // Empty library plays nothing
        wr8(8'h04, {1'b0, ids[0]});
        wr8(8'h03, 8'h00);
        wr8(8'h0C, 8'h01);
        idle();
        // Clear during play drops the rest of the sequence
        wr8(8'h03, {5'h00, lib});
        dly <= 8'h64;
        exp_q.push_back({lib, ids[0]});
        wr8(8'h0C, 8'h01);
        repeat (6) @(posedge clk);
        wr8(8'h0C, 8'h00);
        repeat (110) @(posedge clk);
        `CHK(ab_n, 1)
        `CHK(exp_q.size(), 0)
        // Trigger pin ignored in mode 0, honoured in modes 1 and 2
        dly <= 8'h03;
        for (int m = 0; m < 3; m++) begin
            wr8(8'h01, m[7:0]);
            if (m != 0) exp_q.push_back({lib, ids[0]});
            if (m != 0) exp_q.push_back({lib, ids[1]});
            @(posedge clk);
            go_set <= 1'b1;
            @(posedge clk);
            go_set <= 1'b0;
            idle();
            `CHK(exp_q.size(), 0)
        end
        // Trigger pin clear cancels a running sequence
        dly <= 8'h64;
        exp_q.push_back({lib, ids[0]});
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {go_set, go_clr} <= (k == 0) ? 2'b10 : 2'b01;
            @(posedge clk);
            {go_set, go_clr} <= 2'b00;
            repeat (6) @(posedge clk);
        end
        idle();
        `CHK(ab_n, 2)
        `CHK(exp_q.size(), 0)
        // Calibration, then diagnostic, launched by the start bit
        wr8(8'h01, 8'h07);
        wr8(8'h0C, 8'h01);
        idle();
        wr8(8'h01, 8'h06);
        wr8(8'h0C, 8'h01);
        idle();
        `CHK(cal_n, 1)
        `CHK(diag_n, 1)
        // Real-time byte reaches the load; start is ignored here
        v = 8'($urandom);
        wr8(8'h01, 8'h05);
        wr8(8'h02, v);
        wr8(8'h0C, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(rtp_en, 1'b1)
        `CHK(rtp, v)
        `CHK(busy, 1'b0)
        results();
    end
endmodule

// File: sim/hws_player_model.sv
// Waveform player, calibration and diagnostic engine seen by the sequencer.
// Assumes one-cycle start pulses; answers with a done pulse dly+1 cycles after it takes the start.
`timescale 1ns/1ps
module hws_player_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wave_start,
    input wire logic wave_abort,
    input wire logic cal_start,
    input wire logic diag_start,
    input wire logic [7:0] dly,
    output logic wave_done,
    output logic cal_done,
    output logic diag_done
);
    logic [7:0] cnt;
    logic [2:0] kind;

    // One job at a time; dly lets the bench play prompt or slow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            kind <= 3'h0;
            {wave_done, cal_done, diag_done} <= 3'h0;
        end else begin
            {wave_done, cal_done, diag_done} <= 3'h0;
            if (wave_start || cal_start || diag_start) begin
                cnt <= dly;
                kind <= {wave_start, cal_start, diag_start};
            end else if (wave_abort) begin
                kind <= 3'h0;
            end else if (kind != 3'h0) begin
                if (cnt == 8'h00) begin
                    {wave_done, cal_done, diag_done} <= kind;
                    kind <= 3'h0;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end
endmodule

// File: sim/hws_top_properties.sv
// Checker for the sequencer top: start, playback, abort, mode rules.
// Assumes it is bound to hws_top and sees only its ports.
`timescale 1ns/1ps
module hws_props_chk #(
    parameter int WAIT_UNIT_CYC = hws_pkg::HWS_WAIT_UNIT_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic EXT_GO_SET,
    input wire logic EXT_GO_CLR,
    input wire logic WAVE_START,
    input wire logic WAVE_ABORT,
    input wire logic [2:0] WAVE_LIB,
    input wire logic CAL_START,
    input wire logic DIAG_START,
    input wire logic RTP_EN,
    input wire logic BUSY
);
    logic [2:0] mode_r;
    logic [2:0] lib_r;
    logic go_wr;
    logic clr_wr;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Shadow of mode and library fields, which have no port of their own
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= hws_pkg::HWS_MODE_RST;
            lib_r <= hws_pkg::HWS_LIB_RST;
        end else if (REG_WR && REG_ADDR == hws_pkg::HWS_ADDR_MODE) begin
            mode_r <= REG_WDATA[2:0];
        end else if (REG_WR && REG_ADDR == hws_pkg::HWS_ADDR_LIB) begin
            lib_r <= REG_WDATA[2:0];
        end
    end

    // Host writes to the start bit
    assign go_wr = REG_WR && REG_ADDR == hws_pkg::HWS_ADDR_START && REG_WDATA[0];
    assign clr_wr = REG_WR && REG_ADDR == hws_pkg::HWS_ADDR_START && !REG_WDATA[0];

    AST_GO_START: assert property ((go_wr && !BUSY && mode_r == 3'h0) |=> BUSY)
        else $error("start write did not raise busy");
    AST_WAVE_IN_PLAY: assert property (WAVE_START |-> BUSY && !RTP_EN)
        else $error("waveform request outside playback");
    AST_WAVE_PULSE: assert property (WAVE_START |=> !WAVE_START)
        else $error("waveform request longer than one cycle");
    AST_LIB_SEL: assert property (WAVE_START |-> WAVE_LIB == lib_r && WAVE_LIB != 3'h0)
        else $error("waveform request from wrong library");
    AST_ABORT_BUSY: assert property ((clr_wr && BUSY && mode_r == 3'h0) |=> !BUSY)
        else $error("clear during playback did not stop it");
    AST_ABORT_IDLE: assert property (WAVE_ABORT |-> !BUSY && $past(BUSY))
        else $error("abort pulse without a running sequence");
    AST_EXT_IGNORED: assert property ((EXT_GO_SET && !BUSY && !REG_WR && mode_r != 3'h1 && mode_r != 3'h2)
        |=> !BUSY)
        else $error("trigger pin started outside its modes");
    AST_EXT_SET: assert property ((EXT_GO_SET && !BUSY && !REG_WR && mode_r == 3'h1) |=> BUSY)
        else $error("trigger pin did not start playback");
    AST_EXT_CLR: assert property ((EXT_GO_CLR && BUSY && !REG_WR && mode_r inside {3'h1, 3'h2}) |=> !BUSY)
        else $error("trigger pin clear did not stop playback");
    AST_CAL: assert property ((go_wr && !BUSY && mode_r == 3'h7) |-> ##[1:2] CAL_START)
        else $error("calibration not launched");
    AST_DIAG: assert property ((go_wr && !BUSY && mode_r == 3'h6) |-> ##[1:2] DIAG_START)
        else $error("diagnostic not launched");
    AST_RTP: assert property (RTP_EN |-> mode_r == 3'h5 || $past(mode_r) == 3'h5)
        else $error("real-time drive outside its mode");
    AST_RTP_NOGO: assert property ((go_wr && mode_r == 3'h5) |=> !BUSY)
        else $error("start taken in real-time mode");

    // Main scenarios reached
    cover property (WAVE_ABORT);
    cover property (CAL_START);
    cover property (BUSY ##1 !BUSY);
endmodule

bind hws_top hws_props_chk #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC)) chk_u (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .EXT_GO_SET(EXT_GO_SET), .EXT_GO_CLR(EXT_GO_CLR),
    .WAVE_START(WAVE_START), .WAVE_ABORT(WAVE_ABORT), .WAVE_LIB(WAVE_LIB), .CAL_START(CAL_START),
    .DIAG_START(DIAG_START), .RTP_EN(RTP_EN), .BUSY(BUSY));

// File: verilog/hws_divider.sv
// Divider giving a one-cycle tick every CYC clock cycles.
// Assumes a synchronous clear restarts the period from zero.
`timescale 1ns/1ps
module hws_divider #(
    parameter int CYC = hws_pkg::HWS_WAIT_UNIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    output logic tick
);
    typedef struct packed {
        logic [hws_pkg::HWS_DIV_W-1:0] cnt;
        logic tick;
    } hws_div_state_t;

    localparam logic [hws_pkg::HWS_DIV_W-1:0] LAST = hws_pkg::HWS_DIV_W'(CYC - 1);

    hws_div_state_t s_r;
    hws_div_state_t s_nxt;

    // Count one period, tick at its end
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (clr) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == LAST) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule

// File: verilog/hws_pkg.sv
// Package for the haptic waveform sequencer: register map, reset values,
// mode codes, timing constants and shared types.
// Assumes a 200 MHz core clock and a byte-wide register port in front.
package hws_pkg;

    // Register offsets
    localparam logic [7:0] HWS_ADDR_MODE = 8'h01;
    localparam logic [7:0] HWS_ADDR_RTP = 8'h02;
    localparam logic [7:0] HWS_ADDR_LIB = 8'h03;
    localparam logic [7:0] HWS_ADDR_SLOT_FIRST = 8'h04;
    localparam logic [7:0] HWS_ADDR_SLOT_LAST = 8'h0B;
    localparam logic [7:0] HWS_ADDR_START = 8'h0C;

    // Field positions
    localparam int HWS_START_BIT = 0;
    localparam int HWS_SLOT_WAIT_BIT = 7;

    // Values after reset
    localparam logic [2:0] HWS_MODE_RST = 3'h0;
    localparam logic [7:0] HWS_RTP_RST = 8'h00;
    localparam logic [2:0] HWS_LIB_RST = 3'h1;
    localparam logic [7:0] HWS_SLOT_RST = 8'h00;

    // Mode field codes
    localparam logic [2:0] HWS_MODE_INTERNAL = 3'h0;
    localparam logic [2:0] HWS_MODE_EXT_EDGE = 3'h1;
    localparam logic [2:0] HWS_MODE_EXT_LEVEL = 3'h2;
    localparam logic [2:0] HWS_MODE_REALTIME = 3'h5;
    localparam logic [2:0] HWS_MODE_DIAG = 3'h6;
    localparam logic [2:0] HWS_MODE_CAL = 3'h7;

    // Library code with no waveforms
    localparam logic [2:0] HWS_LIB_EMPTY = 3'h0;

    // Slot count and index of the last slot
    localparam int HWS_SLOTS = 8;
    localparam logic [2:0] HWS_LAST_IDX = 3'h7;

    // Wait unit: time in ms, then derived cycle count
    localparam int HWS_CLK_HZ = 200_000_000;
    localparam int HWS_WAIT_UNIT_MS = 10;
    localparam int HWS_WAIT_UNIT_CYC = (HWS_CLK_HZ / 1000) * HWS_WAIT_UNIT_MS;
    localparam int HWS_DIV_W = 21;

    // Sequencer states
    typedef enum logic [2:0] {
        HWS_IDLE,
        HWS_FETCH,
        HWS_PLAY,
        HWS_WAIT,
        HWS_CAL,
        HWS_DIAG
    } hws_state_t;

    // Waveform request towards the player
    typedef struct packed {
        logic start;
        logic abort;
        logic [2:0] lib;
        logic [6:0] id;
    } hws_wave_req_t;

    // Register write strobe with address and data
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hws_reg_wr_t;

endpackage

// File: verilog/hws_top.sv
// Haptic waveform sequencer: eight slot registers, start trigger, mode,
// library and real-time byte registers, and the playback sequencing engine.
// Assumes a bus front end that presents one-cycle byte writes and a read
// address, a waveform player that pulses done, and trigger pin logic outside.
`timescale 1ns/1ps
module hws_top #(
    parameter int WAIT_UNIT_CYC = hws_pkg::HWS_WAIT_UNIT_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic EXT_GO_SET,
    input wire logic EXT_GO_CLR,
    output logic WAVE_START,
    output logic WAVE_ABORT,
    output logic [2:0] WAVE_LIB,
    output logic [6:0] WAVE_ID,
    input wire logic WAVE_DONE,
    output logic CAL_START,
    input wire logic CAL_DONE,
    output logic DIAG_START,
    input wire logic DIAG_DONE,
    output logic RTP_EN,
    output logic [7:0] RTP_BYTE,
    output logic BUSY
);
    // State of the block in one record, apart from the divider and wait timer, which keep their own
    typedef struct packed {
        hws_pkg::hws_state_t st;
        logic [2:0] idx;
        logic go;
        logic [2:0] mode;
        logic [7:0] rtp;
        logic [2:0] lib;
        logic [7:0][7:0] slot;
        logic [7:0] rdata;
        hws_pkg::hws_wave_req_t wave;
        logic wait_load;
        logic [6:0] wait_cnt;
        logic wait_abort;
        logic cal_start;
        logic diag_start;
        logic rtp_en;
        logic [7:0] rtp_out;
    } hws_top_state_t;

    // Registered state and its next value
    hws_top_state_t s_r;
    hws_top_state_t s_nxt;
    // Bus write bundle and timer handshakes
    hws_pkg::hws_reg_wr_t bus;
    logic tick;
    logic wait_done;

    // Write port gathered into one bundle
    assign bus.wr = REG_WR;
    assign bus.addr = REG_ADDR;
    assign bus.wdata = REG_WDATA;

    // Ten millisecond tick, restarted when a wait begins so the first unit is whole
    hws_divider #(
        .CYC(WAIT_UNIT_CYC)
    ) u_div (
        .clk(CLK),
        .rst_n(RST_N),
        .clr(s_r.wait_load),
        .tick(tick)
    );

    // Wait slot countdown
    hws_wait_timer u_wait (
        .clk(CLK),
        .rst_n(RST_N),
        .load(s_r.wait_load),
        .count(s_r.wait_cnt),
        .abort(s_r.wait_abort),
        .tick(tick),
        .done(wait_done)
    );

    // Register writes, start trigger decode and the sequencing engine
    always_comb begin
        // Decode terms local to this cycle
        logic start_wr;
        logic host_set;
        logic host_clr;
        logic ext_mode;
        logic set_req;
        logic clr_req;
        logic adv;
        logic [7:0] cur;
        logic [3:0] slot_off;
        // Every local starts from a known value
        start_wr = 1'b0;
        host_set = 1'b0;
        host_clr = 1'b0;
        ext_mode = 1'b0;
        set_req = 1'b0;
        clr_req = 1'b0;
        adv = 1'b0;
        cur = 8'h00;
        slot_off = 4'h0;
        // Hold state; pulses fall back to zero
        s_nxt = s_r;
        s_nxt.wave.start = 1'b0;
        s_nxt.wave.abort = 1'b0;
        s_nxt.wait_load = 1'b0;
        s_nxt.wait_abort = 1'b0;
        s_nxt.cal_start = 1'b0;
        s_nxt.diag_start = 1'b0;

        // Plain register stores
        if (bus.wr) begin
            if (bus.addr == hws_pkg::HWS_ADDR_MODE) begin
                s_nxt.mode = bus.wdata[2:0];
            end
            if (bus.addr == hws_pkg::HWS_ADDR_RTP) begin
                s_nxt.rtp = bus.wdata;
            end
            if (bus.addr == hws_pkg::HWS_ADDR_LIB) begin
                s_nxt.lib = bus.wdata[2:0];
            end
            if (bus.addr >= hws_pkg::HWS_ADDR_SLOT_FIRST && bus.addr <= hws_pkg::HWS_ADDR_SLOT_LAST) begin
                slot_off = 4'(bus.addr - hws_pkg::HWS_ADDR_SLOT_FIRST);
                s_nxt.slot[slot_off[2:0]] = bus.wdata;
            end
        end

        // Start bit requests from the host and from the trigger pin logic
        start_wr = bus.wr && (bus.addr == hws_pkg::HWS_ADDR_START);
        host_set = start_wr && bus.wdata[hws_pkg::HWS_START_BIT];
        host_clr = start_wr && !bus.wdata[hws_pkg::HWS_START_BIT];
        ext_mode = (s_r.mode == hws_pkg::HWS_MODE_EXT_EDGE) || (s_r.mode == hws_pkg::HWS_MODE_EXT_LEVEL);
        set_req = host_set || (ext_mode && EXT_GO_SET);
        clr_req = host_clr || (ext_mode && EXT_GO_CLR);
        // Slot under the sequencer's index
        cur = s_r.slot[s_r.idx];

        unique case (s_r.st)
            // Waiting for a start request
            hws_pkg::HWS_IDLE: begin
                if (set_req) begin
                    if (s_r.mode == hws_pkg::HWS_MODE_INTERNAL || ext_mode) begin
                        s_nxt.go = 1'b1;
                        s_nxt.idx = 3'h0;
                        s_nxt.st = hws_pkg::HWS_FETCH;
                    end else if (s_r.mode == hws_pkg::HWS_MODE_CAL) begin
                        s_nxt.go = 1'b1;
                        s_nxt.cal_start = 1'b1;
                        s_nxt.st = hws_pkg::HWS_CAL;
                    end else if (s_r.mode == hws_pkg::HWS_MODE_DIAG) begin
                        s_nxt.go = 1'b1;
                        s_nxt.diag_start = 1'b1;
                        s_nxt.st = hws_pkg::HWS_DIAG;
                    end
                end
            end

            // One cycle per slot: end, skip, wait or play
            hws_pkg::HWS_FETCH: begin
                if (clr_req) begin
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end else if (cur == 8'h00) begin
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end else if (cur[hws_pkg::HWS_SLOT_WAIT_BIT]) begin
                    if (cur[6:0] == 7'h00) begin
                        adv = 1'b1;
                    end else begin
                        s_nxt.wait_load = 1'b1;
                        s_nxt.wait_cnt = cur[6:0];
                        s_nxt.st = hws_pkg::HWS_WAIT;
                    end
                end else if (s_r.lib == hws_pkg::HWS_LIB_EMPTY) begin
                    adv = 1'b1;
                end else begin
                    s_nxt.wave.start = 1'b1;
                    s_nxt.wave.id = cur[6:0];
                    s_nxt.wave.lib = s_r.lib;
                    s_nxt.st = hws_pkg::HWS_PLAY;
                end
            end

            // Player busy; a clear drops the rest of the sequence
            hws_pkg::HWS_PLAY: begin
                if (clr_req) begin
                    s_nxt.wave.abort = 1'b1;
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end else if (WAVE_DONE) begin
                    adv = 1'b1;
                end
            end

            // Timed idle of a wait slot
            hws_pkg::HWS_WAIT: begin
                if (clr_req) begin
                    s_nxt.wait_abort = 1'b1;
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end else if (wait_done) begin
                    adv = 1'b1;
                end
            end

            // Calibration runs to its own end, clears are ignored
            hws_pkg::HWS_CAL: begin
                if (CAL_DONE) begin
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end
            end

            // Diagnostic runs to its own end, clears are ignored
            hws_pkg::HWS_DIAG: begin
                if (DIAG_DONE) begin
                    s_nxt.go = 1'b0;
                    s_nxt.st = hws_pkg::HWS_IDLE;
                end
            end

            // Unused state codes fall back to idle with the start bit low
            default: begin
                s_nxt.go = 1'b0;
                s_nxt.st = hws_pkg::HWS_IDLE;
            end
        endcase

        // Step to the next slot, or finish after the eighth
        if (adv) begin
            if (s_r.idx == hws_pkg::HWS_LAST_IDX) begin
                s_nxt.go = 1'b0;
                s_nxt.st = hws_pkg::HWS_IDLE;
            end else begin
                s_nxt.idx = s_r.idx + 3'h1;
                s_nxt.st = hws_pkg::HWS_FETCH;
            end
        end

        // Real-time byte goes to the load only in its own mode
        s_nxt.rtp_en = (s_r.mode == hws_pkg::HWS_MODE_REALTIME);
        s_nxt.rtp_out = s_r.rtp;

        // Read data, one cycle behind the address; unmapped reads zero
        s_nxt.rdata = 8'h00;
        if (REG_ADDR == hws_pkg::HWS_ADDR_MODE) begin
            s_nxt.rdata = {5'h00, s_r.mode};
        end else if (REG_ADDR == hws_pkg::HWS_ADDR_RTP) begin
            s_nxt.rdata = s_r.rtp;
        end else if (REG_ADDR == hws_pkg::HWS_ADDR_LIB) begin
            s_nxt.rdata = {5'h00, s_r.lib};
        end else if (REG_ADDR >= hws_pkg::HWS_ADDR_SLOT_FIRST && REG_ADDR <= hws_pkg::HWS_ADDR_SLOT_LAST) begin
            s_nxt.rdata = s_r.slot[3'(REG_ADDR - hws_pkg::HWS_ADDR_SLOT_FIRST)];
        end else if (REG_ADDR == hws_pkg::HWS_ADDR_START) begin
            s_nxt.rdata = {7'h00, s_r.go};
        end
    end

    // Reset: slots and start bit zero, library one
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
            s_r.st <= hws_pkg::HWS_IDLE;
            s_r.mode <= hws_pkg::HWS_MODE_RST;
            s_r.rtp <= hws_pkg::HWS_RTP_RST;
            s_r.lib <= hws_pkg::HWS_LIB_RST;
            s_r.slot <= {hws_pkg::HWS_SLOTS{hws_pkg::HWS_SLOT_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign REG_RDATA = s_r.rdata;
    assign WAVE_START = s_r.wave.start;
    assign WAVE_ABORT = s_r.wave.abort;
    assign WAVE_LIB = s_r.wave.lib;
    assign WAVE_ID = s_r.wave.id;
    assign CAL_START = s_r.cal_start;
    assign DIAG_START = s_r.diag_start;
    assign RTP_EN = s_r.rtp_en;
    assign RTP_BYTE = s_r.rtp_out;
    assign BUSY = s_r.go;
endmodule

// File: verilog/hws_wait_timer.sv
// Wait timer counting down a seven-bit value in divider ticks.
// Assumes load is only given with a non-zero count.
`timescale 1ns/1ps
module hws_wait_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [6:0] count,
    input wire logic abort,
    input wire logic tick,
    output logic done
);
    typedef struct packed {
        logic [6:0] cnt;
        logic run;
        logic done;
    } hws_wt_state_t;

    hws_wt_state_t s_r;
    hws_wt_state_t s_nxt;

    // Load, count down on ticks, pulse done at the last one
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (abort) begin
            s_nxt.run = 1'b0;
        end else if (load) begin
            s_nxt.cnt = count;
            s_nxt.run = 1'b1;
        end else if (s_r.run && tick) begin
            if (s_r.cnt == 7'h01) begin
                s_nxt.run = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule
